// ### bst_cfg.svh
// Constants for the boundary-scan test port: codes, widths, reset values
`ifndef BST_CFG_SVH
`define BST_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define BST_IR_W 3
`define BST_ID_W 32

// ----------------------------------------------------------------
// Instruction codes (only IDCODE selects a long register here)
// ----------------------------------------------------------------
`define BST_INS_EXTEST 3'h0
`define BST_INS_IDCODE 3'h1
`define BST_INS_SAMPLEZ 3'h2
`define BST_INS_SAMPLE 3'h4
`define BST_INS_BYPASS 3'h7

// ----------------------------------------------------------------
// Capture patterns and reset values
// ----------------------------------------------------------------
`define BST_IR_CAPTURE 3'h1
// Identification code: value is arbitrary, bit 0 set as the standard asks
`define BST_ID_CODE 32'h0A5C_3001
// Consecutive TMS-high rising edges that must reach the reset state
`define BST_RESET_EDGES 3'h5

`endif

// ### bst_pkg.sv
// Types shared by the boundary-scan test port
package bst_pkg;

  // ----------------------------------------------------------------
  // Controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_TLR  = 16'h0001,
    ST_RTI  = 16'h0002,
    ST_SDRS = 16'h0004,
    ST_CDR  = 16'h0008,
    ST_SDR  = 16'h0010,
    ST_E1DR = 16'h0020,
    ST_PDR  = 16'h0040,
    ST_E2DR = 16'h0080,
    ST_UDR  = 16'h0100,
    ST_SIRS = 16'h0200,
    ST_CIR  = 16'h0400,
    ST_SIR  = 16'h0800,
    ST_E1IR = 16'h1000,
    ST_PIR  = 16'h2000,
    ST_E2IR = 16'h4000,
    ST_UIR  = 16'h8000
  } bst_state_t;

endpackage : bst_pkg

// ### bst_tap.sv
// Boundary-scan test access port, sampled from the system clock
//
// Summary of operation
// - Standard test port state machine and registers
// - TDI and TMS synchronisers reset high, as floating pins would read
// - Power-up reset state leaves memory undisturbed
// - Inputs sampled on test clock rising edge
// - TDO and its enable change only on test clock falling edge or system reset; TAP_IN_RESET follows the state on the rising edge
// - Instruction selects the data register
// - TDI enters selected register MSB
// - TDO shows selected register LSB
// - TDO driven only in shift states
// - Five TMS-high rising edges force reset
// - Test reset never touches memory operation
// - Power-up reset puts TDO at high-Z
// - Three-bit instruction, IDCODE on every reset
// - Capture-IR loads 01 into low bits
// - Bypass is one bit, cleared on capture
// - Capture-DR under IDCODE loads 32-bit code
`timescale 1ns/100ps
`default_nettype none
`include "bst_cfg.svh"

module bst_tap
  import bst_pkg::*;
(
  // System clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Test port pins
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE_N,
  // Status towards the memory core, which it never gates
  output logic TAP_IN_RESET
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic tck_s1, tck_s2, tck_s3; // Test clock synchroniser and history
  logic tms_s1, tms_s2; // Mode select synchroniser
  logic tdi_s1, tdi_s2; // Data-in synchroniser
  bst_state_t state; // Controller state
  bst_state_t next_state; // State after the next rising edge
  logic [`BST_IR_W-1:0] ir; // Active instruction
  logic [`BST_IR_W-1:0] ir_shift; // Instruction shift stage
  logic [`BST_ID_W-1:0] id_shift; // Identification shift stage
  logic bypass; // Single-bit bypass stage
  logic [2:0] tms_run; // Helper: consecutive TMS-high edges
  wire tck_rise; // Rising test clock edge seen
  wire tck_fall; // Falling test clock edge seen
  wire sel_id; // IDCODE register in the path
  wire shifting; // Shift-IR or Shift-DR
  wire next_tdo; // Bit to present at the next fall

  // ----------------------------------------------------------------
  // Next state function of the controller
  // ----------------------------------------------------------------
  function automatic bst_state_t step(input bst_state_t s, input logic m);
    case (s)
      ST_TLR: step = m ? ST_TLR : ST_RTI;
      ST_RTI: step = m ? ST_SDRS : ST_RTI;
      ST_SDRS: step = m ? ST_SIRS : ST_CDR;
      ST_CDR: step = m ? ST_E1DR : ST_SDR;
      ST_SDR: step = m ? ST_E1DR : ST_SDR;
      ST_E1DR: step = m ? ST_UDR : ST_PDR;
      ST_PDR: step = m ? ST_E2DR : ST_PDR;
      ST_E2DR: step = m ? ST_UDR : ST_SDR;
      ST_UDR: step = m ? ST_SDRS : ST_RTI;
      ST_SIRS: step = m ? ST_TLR : ST_CIR;
      ST_CIR: step = m ? ST_E1IR : ST_SIR;
      ST_SIR: step = m ? ST_E1IR : ST_SIR;
      ST_E1IR: step = m ? ST_UIR : ST_PIR;
      ST_PIR: step = m ? ST_E2IR : ST_PIR;
      ST_E2IR: step = m ? ST_UIR : ST_SIR;
      ST_UIR: step = m ? ST_SDRS : ST_RTI;
      // Illegal code: recover through reset
      default: step = ST_TLR;
    endcase
  endfunction : step

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Data pins reset high, as a floating pin with pull-up would read
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
    end else begin
      tck_s1 <= TCK;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= TMS;
      tms_s2 <= tms_s1;
      tdi_s1 <= TDI;
      tdi_s2 <= tdi_s1;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and path selection
  // ----------------------------------------------------------------
  // A test clock held low never yields an edge, so the port stays idle
  assign tck_rise = tck_s2 & ~tck_s3;
  assign tck_fall = ~tck_s2 & tck_s3;
  assign next_state = step(state, tms_s2);
  assign sel_id = (ir == `BST_INS_IDCODE);
  assign shifting = (state == ST_SIR) || (state == ST_SDR);
  // Instruction path in Shift-IR, else the register the code picks
  assign next_tdo = (state == ST_SIR) ? ir_shift[0] :
                    sel_id ? id_shift[0] : bypass;
  assign TAP_IN_RESET = (state == ST_TLR);

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  // Advances only on a sampled rising edge of the test clock
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  // Update happens at the fall inside Update-IR, as the standard has it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ir <= `BST_INS_IDCODE;
      ir_shift <= `BST_IR_CAPTURE;
    end else if (state == ST_TLR) begin
      ir <= `BST_INS_IDCODE;
    end else if (tck_rise && state == ST_CIR) begin
      ir_shift <= `BST_IR_CAPTURE;
    end else if (tck_rise && state == ST_SIR) begin
      ir_shift <= {tdi_s2, ir_shift[`BST_IR_W-1:1]};
    end else if (tck_fall && state == ST_UIR) begin
      ir <= ir_shift;
    end
  end

  // ----------------------------------------------------------------
  // Data registers: identification and bypass
  // ----------------------------------------------------------------
  // Codes other than IDCODE use bypass; no boundary cells are modelled
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      id_shift <= `BST_ID_CODE;
      bypass <= 1'b0;
    end else if (tck_rise && state == ST_CDR) begin
      if (sel_id) begin
        id_shift <= `BST_ID_CODE;
      end else begin
        bypass <= 1'b0;
      end
    end else if (tck_rise && state == ST_SDR) begin
      if (sel_id) begin
        id_shift <= {tdi_s2, id_shift[`BST_ID_W-1:1]};
      end else begin
        bypass <= tdi_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output and its enable
  // ----------------------------------------------------------------
  // Driven only from a falling edge or system reset, so the far end samples stable data
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      TDO <= 1'b0;
      TDO_OE_N <= 1'b1;
    end else if (tck_fall) begin
      TDO <= next_tdo;
      TDO_OE_N <= ~shifting;
    end
  end

  // ----------------------------------------------------------------
  // Helper counter for the forced-reset check
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tms_run <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s2) begin
        tms_run <= 3'h0;
      end else if (tms_run != `BST_RESET_EDGES) begin
        tms_run <= tms_run + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_state_on_rise;
    @(posedge CLK) disable iff (RESET)
    (state != $past(state)) |-> $past(tck_rise);
  endproperty
  a_state_on_rise: assert property (p_state_on_rise)
    else $error("State moved without a rising test clock edge");

  property p_tdo_on_fall;
    @(posedge CLK) disable iff (RESET)
    $changed(TDO) || $changed(TDO_OE_N) |-> $past(tck_fall);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("TDO changed away from a falling edge");

  property p_oe_shift;
    @(posedge CLK) disable iff (RESET)
    tck_fall |=> (TDO_OE_N == !$past(shifting));
  endproperty
  a_oe_shift: assert property (p_oe_shift)
    else $error("TDO enable does not follow the shift states");

  property p_five_ones;
    @(posedge CLK) disable iff (RESET)
    (tms_run == `BST_RESET_EDGES) |-> (state == ST_TLR);
  endproperty
  a_five_ones: assert property (p_five_ones)
    else $error("Five TMS-high edges did not reach reset");

  property p_ir_reset;
    @(posedge CLK) disable iff (RESET)
    (state == ST_TLR) |=> (ir == `BST_INS_IDCODE);
  endproperty
  a_ir_reset: assert property (p_ir_reset)
    else $error("Instruction is not IDCODE in reset state");

  property p_capture_ir;
    @(posedge CLK) disable iff (RESET)
    (tck_rise && state == ST_CIR) |=> (ir_shift[1:0] == 2'b01);
  endproperty
  a_capture_ir: assert property (p_capture_ir)
    else $error("Capture-IR pattern missing");

  property p_bypass_clear;
    @(posedge CLK) disable iff (RESET)
    (tck_rise && state == ST_CDR && !sel_id) |=> (bypass == 1'b0);
  endproperty
  a_bypass_clear: assert property (p_bypass_clear)
    else $error("Bypass not cleared on capture");

  property p_id_capture;
    @(posedge CLK) disable iff (RESET)
    (tck_rise && state == ST_CDR && sel_id) |=> (id_shift == `BST_ID_CODE);
  endproperty
  a_id_capture: assert property (p_id_capture)
    else $error("Identification code not captured");

  property p_msb_in;
    @(posedge CLK) disable iff (RESET)
    (tck_rise && state == ST_SDR && sel_id) |=>
      (id_shift[`BST_ID_W-1] == $past(tdi_s2));
  endproperty
  a_msb_in: assert property (p_msb_in)
    else $error("TDI did not enter the MSB");

  property p_lsb_out;
    @(posedge CLK) disable iff (RESET)
    (tck_fall && state == ST_SDR && sel_id) |=> (TDO == $past(id_shift[0]));
  endproperty
  a_lsb_out: assert property (p_lsb_out)
    else $error("TDO does not show the LSB");

endmodule : bst_tap

`default_nettype wire

// ### bst_jtag_host.sv
// Behavioural test controller driving the scan port pins
`timescale 1ns/100ps
`default_nettype none

module bst_jtag_host (
  // Link pins towards the port
  output logic tck,
  output logic tms,
  output logic tdi,
  // Serial return and its enable, active low
  input wire logic tdo,
  input wire logic tdo_oe_n,
  // Resolved level of the return line
  output logic tdo_line
);
  // Last driven level; a released line shows its inverse
  logic tdo_last;

  // ----
  // Idle pins
  // ----
  // Test clock parked low between frames, so the port never steps
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    tdo_last = 1'b0;
  end

  // Host only reads the return line, never drives it
  always @(tdo or tdo_oe_n) begin
    if (!tdo_oe_n) begin
      tdo_last = tdo;
    end
  end
  assign tdo_line = tdo_oe_n ? ~tdo_last : tdo;

  // One 800 ns test clock period; mode bits decide the walk
  task automatic step(input logic t_ms, input logic t_di,
    output logic seen, output logic seen_oe_n, output logic moved);
    logic at_rise;
    logic oe_rise;
    tms = t_ms;
    tdi = t_di;
    #400;
    tck = 1'b1;
    at_rise = tdo_line;
    oe_rise = tdo_oe_n;
    #300;
    // Late flip: only the level at the rise may count
    tms = ~t_ms;
    tdi = ~t_di;
    #100;
    seen = tdo_line;
    seen_oe_n = tdo_oe_n;
    moved = (at_rise !== seen) || (oe_rise !== seen_oe_n);
    tck = 1'b0;
  endtask : step
endmodule : bst_jtag_host
`default_nettype wire

// ### bst_tap_tb_top.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
`include "bst_cfg.svh"

module bst_tap_tb_top;
  // System side and link nets
  logic CLK;
  logic RESET;
  wire tck;
  wire tms;
  wire tdi;
  wire tdo;
  wire tdo_oe_n;
  wire tap_rst;
  wire tdo_line;
  int error_cnt;
  int comparisons;
  int cycles;
  logic s_bit;
  logic s_oe;
  logic s_mov;
  // Every code once; the last one returns to the identifier
  logic [2:0] codes [5] = '{`BST_INS_EXTEST, `BST_INS_SAMPLEZ,
    `BST_INS_SAMPLE, `BST_INS_BYPASS, `BST_INS_IDCODE};

  // ----
  // Instances
  // ----
  bst_tap u_dut (.CLK(CLK), .RESET(RESET), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TDO(tdo), .TDO_OE_N(tdo_oe_n), .TAP_IN_RESET(tap_rst));
  bst_jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .tdo_line(tdo_line));

  // 10 MHz system clock
  initial CLK = 1'b0;
  always #50 CLK = ~CLK;

  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Mode bits taken LSB first; quiet expects the return line released
  task automatic walk(input logic [7:0] path, input int n,
    input logic quiet);
    for (int i = 0; i < n; i++) begin
      u_host.step(path[i], 1'b1, s_bit, s_oe, s_mov);
      check("tdo_steady", s_mov, 1'b0);
      if (quiet) begin
        check("idle_oe_n", s_oe, 1'b1);
      end
    end
  endtask : walk

  // Shift n bits, leaving on the last one
  task automatic scan(input int n, input logic [63:0] din,
    input logic [63:0] dexp, input string what);
    for (int i = 0; i < n; i++) begin
      u_host.step(i == n - 1, din[i], s_bit, s_oe, s_mov);
      check(what, s_bit, dexp[i]);
      check("shift_oe_n", s_oe, 1'b0);
      check("tdo_steady", s_mov, 1'b0);
    end
  endtask : scan

  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // ----
  // Scenarios
  // ----
  // Port rests in reset with its output released while unclocked
  task automatic t_power_up();
    repeat (20) @(posedge CLK);
    // Pins change 1 ns after a clock edge from here on
    #1;
    check("in_reset", tap_rst, 1'b1);
    check("oe_n", tdo_oe_n, 1'b1);
  endtask : t_power_up

  // Identifier shifted out, then the data fed in follows it
  task automatic t_idcode();
    walk(8'h02, 4, 1'b1);
    scan(40, 64'h0000_0000_0000_00C5, {32'h0000_00C5, `BST_ID_CODE},
      "id_bits");
    walk(8'h01, 2, 1'b1);
  endtask : t_idcode

  // Load a code, then check which path sits between the pins
  task automatic t_instr(input logic [2:0] code);
    walk(8'h03, 4, 1'b1);
    scan(3, {61'h0, code}, 64'h0000_0000_0000_0001,
      "ir_capture");
    walk(8'h01, 2, 1'b1);
    walk(8'h01, 3, 1'b1);
    if (code == `BST_INS_IDCODE) begin
      scan(33, 64'h0000_0000_0000_0001, {32'h0000_0001, `BST_ID_CODE},
        "id_path");
    end else begin
      // Last bit in is 1, so the next capture must clear it
      scan(4, 64'h0000_0000_0000_000B, 64'h0000_0000_0000_0006,
        "bypass_path");
    end
    walk(8'h01, 2, 1'b1);
  endtask : t_instr

  // Five high mode bits from Shift-IR; four are not enough
  task automatic t_tms_reset();
    walk(8'h03, 4, 1'b1);
    scan(3, 64'h0000_0000_0000_0007, 64'h0000_0000_0000_0001,
      "ir_cap");
    walk(8'h0F, 3, 1'b0);
    check("in_reset_4", tap_rst, 1'b0);
    walk(8'h01, 1, 1'b1);
    check("in_reset_5", tap_rst, 1'b1);
    // All-ones code loaded at Update-IR must be dropped for the identifier
    walk(8'h02, 4, 1'b1);
    scan(32, 64'h0, {32'h0, `BST_ID_CODE}, "id_after_reset");
    walk(8'h01, 2, 1'b1);
  endtask : t_tms_reset

  // System reset in mid-shift releases the line and drops the code
  task automatic t_mid_reset();
    walk(8'h03, 4, 1'b1);
    scan(3, {61'h0, `BST_INS_BYPASS}, 64'h0000_0000_0000_0001,
      "ir_cap_rst");
    walk(8'h01, 2, 1'b1);
    walk(8'h01, 3, 1'b1);
    // Let the fall into Shift-DR turn the driver on first
    repeat (4) @(posedge CLK);
    #1;
    check("oe_n_shift", tdo_oe_n, 1'b0);
    RESET = 1'b1;
    @(posedge CLK);
    #1;
    check("oe_n_rst", tdo_oe_n, 1'b1);
    check("in_reset_rst", tap_rst, 1'b1);
    RESET = 1'b0;
    // Two quiet edges after release, then the identifier again
    repeat (2) @(posedge CLK);
    #1;
    check("oe_n_post", tdo_oe_n, 1'b1);
    check("in_reset_post", tap_rst, 1'b1);
    walk(8'h02, 4, 1'b1);
    scan(32, 64'h0, {32'h0, `BST_ID_CODE}, "id_after_rst");
    walk(8'h01, 2, 1'b1);
  endtask : t_mid_reset

  // ----
  // Main sequence
  // ----
  initial begin
    error_cnt = 0;
    comparisons = 0;
    RESET = 1'b1;
    repeat (4) @(posedge CLK);
    #1;
    RESET = 1'b0;
    fork
      begin
        t_power_up();
        t_idcode();
        foreach (codes[i]) begin
          t_instr(codes[i]);
        end
        t_tms_reset();
        t_mid_reset();
      end
      begin
        // Hang guard, well above the roughly 2140 cycles needed
        for (cycles = 0; cycles < 4000; cycles++) begin
          @(posedge CLK);
        end
        error_cnt++;
      end
    join_any
    summarize();
  end
endmodule : bst_tap_tb_top
`default_nettype wire
